// >>> core/prs_pkg.sv
// package: constants, types and timing counts for the release/signature block
package prs_pkg;
    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PUW_MIN_US = 1000;
    localparam int PUW_CYCLES = (PUW_MIN_US * 1000000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int RES1_MAX_NS = 3000;
    localparam int RES1_CYCLES = (RES1_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int RES2_MAX_NS = 30000;
    localparam int RES2_CYCLES = (RES2_MAX_NS * 1000) / CLK_PERIOD_PS;

    // ****************************************
    // instruction codes
    // ****************************************
    localparam logic [7:0] OPC_RES_DEFAULT = 8'h00_AB;
    localparam logic [7:0] SIG_DEFAULT = 8'h00_5A; // arbitrary value
    localparam logic [7:0] OPC_DEEP_SLEEP = 8'h00_B9;
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h00_06;
    localparam logic [7:0] OPC_PAGE_WRITE = 8'h00_02;
    localparam logic [7:0] OPC_SECTOR_CLR = 8'h00_D8;
    localparam logic [7:0] OPC_FULL_CLR = 8'h00_C7;
    localparam logic [7:0] OPC_STATUS_WR = 8'h00_01;
    localparam int DUMMY_BYTES = 3;
    localparam int BIT_CNT_W = 6;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0]
    {
        PM_STANDBY = 2'b00,
        PM_DEEP = 2'b01,
        PM_WAKING = 2'b11
    } prs_pmode_t;

    typedef struct packed
    {
        logic sel;
        logic sclk;
        logic din;
    } prs_link_t;

    typedef struct packed
    {
        logic dout;
        logic doutEn;
    } prs_out_t;
endpackage

// >>> core/prs_sync.sv
// three-stage synchroniser with agreement filter for link pins
module prs_sync
(
    input wire logic clk, // block clock
    input wire logic rst, // async reset, active high
    input wire logic in, // raw pin
    output logic out // filtered level
);
    logic s1;
    logic s2;
    logic s3;
    // first stage feeds only the second; level moves once s2 and s3 agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= in;
            s2 <= s1;
            s3 <= s2;
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            out <= 1'b0;
        else if (s2 == s3)
            out <= s3;
    end
endmodule

// >>> core/prs_core.sv
// release-from-deep-sleep / signature instruction handler with power-up lock
// Function
// - in deep sleep, only the release/signature instruction is acted upon
// - executing release/signature leaves deep sleep
// - release/signature returns the 8-bit signature when no cycle runs
// - release/signature during a busy cycle is not decoded, cycle untouched
// - after dummies, signature shifts out, one bit per falling clock
// - continued clocks with select low repeat the signature
// - select rise enters standby, at once if deep sleep was not entered
// - from deep sleep after signature read, standby after long delay
// - early select rise after opcode: standby after short delay
// - in standby, the next selection decodes instructions normally
// - power-on reset holds logic reset and unresponsive
// - write-type instructions ignored for the power-up write delay
// - power-up state is standby with write-enable latch cleared
// - deep sleep entered only by exact 8-bit command, refused when busy
// - busy flag is 1 during a self-timed cycle, 0 afterwards
module prs_core
#(
    parameter logic [7:0] RES_OPCODE = prs_pkg::OPC_RES_DEFAULT,
    parameter logic [7:0] SIGNATURE = prs_pkg::SIG_DEFAULT, // arbitrary
    parameter int PUW_COUNT = prs_pkg::PUW_CYCLES,
    parameter int RES1_COUNT = prs_pkg::RES1_CYCLES,
    parameter int RES2_COUNT = prs_pkg::RES2_CYCLES
)
(
    input wire logic clk, // 250 MHz block clock
    input wire logic rst, // power-on reset, active high
    input wire prs_pkg::prs_link_t link, // raw select, clock, data pins
    input wire logic cycleBusy, // self-timed cycle running
    output prs_pkg::prs_out_t qOut, // serial output and its enable
    output logic deepSleep, // device is in (or leaving) deep sleep
    output logic standby, // device is in standby, ready for select
    output logic writeEnableLatch, // latch set by write-enable command
    output logic writeLock, // power-up write delay still running
    output logic writeCmdPulse, // accepted write-type opcode, one cycle
    output logic [7:0] acceptedOpcode, // opcode of last accepted command
    output logic cycleBusyFlag // busy flag as seen by status reads
);
    import prs_pkg::*;

    // count value once opcode and all dummy bytes are in
    localparam logic [BIT_CNT_W-1:0] LAST_CNT =
        BIT_CNT_W'(8 * (DUMMY_BYTES + 1));

    // refuse settings the counters cannot serve
    if (PUW_COUNT < 1 || RES1_COUNT < 1 || RES2_COUNT < RES1_COUNT
        || 8 * (DUMMY_BYTES + 1) >= 2 ** BIT_CNT_W)
    begin : g_bad_params
        $error("prs_core: bad timing parameters");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic selN;
    logic selOn;
    logic sck;
    logic sdi;
    // select filtered inverted so the filter's reset level means deselected
    prs_sync uSel (.clk(clk), .rst(rst), .in(!link.sel), .out(selOn));
    assign selN = !selOn;
    prs_sync uSck (.clk(clk), .rst(rst), .in(link.sclk), .out(sck));
    prs_sync uSdi (.clk(clk), .rst(rst), .in(link.din), .out(sdi));

    logic sckD;
    logic selD;
    // edge history; select resets high so reset is not seen as a frame end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sckD <= 1'b0;
            selD <= 1'b1;
        end
        else
        begin
            sckD <= sck;
            selD <= selN;
        end
    end
    logic active;
    logic sckRise;
    logic sckFall;
    logic selRise;
    // a frame counts only after a falling select has been seen
    logic framed;
    assign active = framed && !selN;
    assign sckRise = active && sck && !sckD;
    assign sckFall = active && !sck && sckD;
    assign selRise = selN && !selD;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            framed <= 1'b0;
        else if (!selN && selD)
            framed <= 1'b1;
        else if (selN)
            framed <= 1'b0;
    end

    // ****************************************
    // input shifter, msb first
    // ****************************************
    logic [7:0] shiftIn;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [7:0] opcode;
    logic opValid;
    logic [7:0] next_shift;
    assign next_shift = {shiftIn[6:0], sdi};
    // bits counted up to opcode plus dummies, then held
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            shiftIn <= 8'h00_00;
            bitCnt <= '0;
            opcode <= 8'h00_00;
            opValid <= 1'b0;
        end
        else if (!active)
        begin
            bitCnt <= '0;
            opValid <= 1'b0;
        end
        else if (sckRise)
        begin
            shiftIn <= next_shift;
            if (bitCnt != LAST_CNT)
                bitCnt <= bitCnt + 1'b1;
            if (bitCnt == BIT_CNT_W'(7))
            begin
                opcode <= next_shift;
                opValid <= 1'b1;
            end
        end
    end

    logic isRes;
    logic exactByte;
    // release opcode not decoded at all while a cycle runs
    assign isRes = opValid && opcode == RES_OPCODE && !cycleBusy;
    assign exactByte = bitCnt == BIT_CNT_W'(8);

    // ****************************************
    // signature output, falling-edge shift, repeating
    // ****************************************
    logic [2:0] outBit;
    logic sigDone;
    logic outOn;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            outBit <= 3'd0;
            sigDone <= 1'b0;
            outOn <= 1'b0;
            qOut <= '0;
        end
        else if (!active || !isRes || bitCnt != LAST_CNT)
        begin
            outBit <= 3'd0;
            outOn <= 1'b0;
            qOut <= '0;
            if (!active)
                sigDone <= 1'b0;
        end
        else if (sckFall)
        begin
            qOut.dout <= SIGNATURE[3'd7 - outBit];
            qOut.doutEn <= 1'b1;
            outBit <= outBit + 3'd1;
            outOn <= 1'b1;
        end
        // all eight bits shown; host latches bit 0 on this rise
        else if (sckRise && outOn && outBit == 3'd0)
            sigDone <= 1'b1;
    end

    // ****************************************
    // power mode
    // ****************************************
    prs_pmode_t pmode;
    logic [$clog2(RES2_COUNT+1)-1:0] wakeCnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pmode <= PM_STANDBY;
            wakeCnt <= '0;
        end
        else
        begin
            unique case (pmode)
                PM_STANDBY:
                    if (selRise && opValid && exactByte && !cycleBusy
                        && opcode == OPC_DEEP_SLEEP)
                        pmode <= PM_DEEP;
                PM_DEEP:
                    if (selRise && isRes)
                    begin
                        pmode <= PM_WAKING;
                        wakeCnt <= sigDone
                            ? ($bits(wakeCnt))'(RES2_COUNT)
                            : ($bits(wakeCnt))'(RES1_COUNT);
                    end
                PM_WAKING:
                    if (wakeCnt <= 1)
                        pmode <= PM_STANDBY;
                    else
                        wakeCnt <= wakeCnt - 1'b1;
                default:
                    pmode <= PM_STANDBY;
            endcase
        end
    end
    assign deepSleep = pmode != PM_STANDBY;
    assign standby = pmode == PM_STANDBY && selN && !cycleBusy;

    // ****************************************
    // power-up write lock and write-enable latch
    // ****************************************
    logic [$clog2(PUW_COUNT+1)-1:0] puwCnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            puwCnt <= ($bits(puwCnt))'(PUW_COUNT);
        else if (puwCnt != 0)
            puwCnt <= puwCnt - 1'b1;
    end
    assign writeLock = puwCnt != 0;

    logic isWriteOp;
    assign isWriteOp = opcode == OPC_WRITE_ENABLE_CMD || opcode == OPC_PAGE_WRITE
        || opcode == OPC_SECTOR_CLR || opcode == OPC_FULL_CLR
        || opcode == OPC_STATUS_WR;
    // write commands pass only in standby, idle and past the lock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            writeCmdPulse <= 1'b0;
            acceptedOpcode <= 8'h00_00;
            writeEnableLatch <= 1'b0;
        end
        else
        begin
            writeCmdPulse <= 1'b0;
            if (selRise && opValid && isWriteOp && !writeLock
                && pmode == PM_STANDBY && !cycleBusy)
            begin
                writeCmdPulse <= 1'b1;
                acceptedOpcode <= opcode;
                if (opcode == OPC_WRITE_ENABLE_CMD && exactByte)
                    writeEnableLatch <= 1'b1;
            end
            else if (cycleBusy)
                writeEnableLatch <= 1'b0;
        end
    end
    assign cycleBusyFlag = cycleBusy;
endmodule

// >>> verification/prs_core_monitor.sv
// port checker for the release/signature block
module prs_core_monitor
#(
    parameter int PUW_COUNT = 400
)
(
    input wire logic clk, // block clock
    input wire logic rst, // power-on reset
    input wire prs_pkg::prs_link_t link, // host pins
    input wire logic cycleBusy, // cycle running
    input wire prs_pkg::prs_out_t qOut, // serial out
    input wire logic deepSleep, // deep sleep
    input wire logic standby, // standby
    input wire logic writeEnableLatch, // latch
    input wire logic writeLock, // power-up lock
    input wire logic writeCmdPulse, // write accept
    input wire logic [7:0] acceptedOpcode, // last opcode
    input wire logic cycleBusyFlag // status flag
);
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;
    // ********************
    // properties
    // ********************
    localparam int LOCK_MAX = PUW_COUNT + 8;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_flag; cycleBusyFlag == cycleBusy; endproperty
    a_flag: assert property (p_flag) else $error("flag");
    property p_init; $fell(rst) |-> !deepSleep && !writeEnableLatch;
    endproperty
    a_init: assert property (p_init) else $error("init");
    property p_lock; $fell(rst) |-> ##[1:LOCK_MAX] !writeLock; endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_pulse; writeCmdPulse |-> !writeLock && !deepSleep;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse");
    // select must settle through the synchroniser before output stops
    property p_idle; link.sel [*8] |-> !qOut.doutEn; endproperty
    a_idle: assert property (p_idle) else $error("idle");
    // the output decision is taken one edge before the enable rises
    property p_busy; $rose(qOut.doutEn) |-> !$past(cycleBusy);
    endproperty
    a_busy: assert property (p_busy) else $error("busy");
    property p_deep; $rose(deepSleep) |-> link.sel && !$past(cycleBusy);
    endproperty
    a_deep: assert property (p_deep) else $error("deep");
    // leaving deep sleep is never immediate, at least the short delay
    property p_wake; deepSleep && $rose(link.sel) |-> deepSleep [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    c_out: cover property ($rose(qOut.doutEn));
    c_in: cover property ($rose(deepSleep));
    c_wake: cover property ($fell(deepSleep));
endmodule

bind prs_core prs_core_monitor #(.PUW_COUNT(PUW_COUNT)) i_mon (.clk(clk),
    .rst(rst), .link(link), .cycleBusy(cycleBusy), .qOut(qOut),
    .deepSleep(deepSleep), .standby(standby),
    .writeEnableLatch(writeEnableLatch), .writeLock(writeLock),
    .writeCmdPulse(writeCmdPulse), .acceptedOpcode(acceptedOpcode),
    .cycleBusyFlag(cycleBusyFlag));

// >>> verification/prs_host_model.sv
// host model driving the serial link
module prs_host_model
(
    input wire logic clk, // block clock
    input wire prs_pkg::prs_out_t qOut, // device output
    output prs_pkg::prs_link_t link // select, clock, data
);
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;
    logic enSeen;
    // idle: deselected, link clock still
    initial link = 3'h4;
    // one frame, msb first; 64 ns link period, pins move at falling clk
    task automatic xfer(input logic [7:0] opc, input int nIn, input int nRd,
        output logic [15:0] rd);
        int k;
        rd = 16'h0000;
        enSeen = 1'h0;
        link.sel = 1'h0;
        for (k = 0; k < nIn + nRd; k++)
        begin
            link.din = (k < 8) ? opc[7 - k] : ~link.din;
            repeat (8) @(negedge clk);
            link.sclk = 1'h1;
            // undriven line reads as the inverse of the last bit
            rd = {rd[14:0], qOut.doutEn ? qOut.dout : ~rd[0]};
            enSeen |= qOut.doutEn;
            repeat (8) @(negedge clk);
            link.sclk = 1'h0;
        end
        repeat (4) @(negedge clk);
        link.sel = 1'h1;
        link.din = ~link.din;
    endtask
endmodule

// >>> verification/prs_testbench.sv
// self-checking bench for the release/signature block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import prs_pkg::*;
    localparam logic [7:0] SIG = 8'h00_C3;
    localparam int PUW = 400;
    localparam int R1 = 4;
    localparam int R2 = 40;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cycleBusy = 1'h0;
    prs_link_t link;
    prs_out_t qOut;
    logic deepSleep, standby, write_enable_latch, writeLock, busyFlag;
    logic [7:0] accOpc;
    logic [15:0] rd;
    int mismatches = 0;
    int n_checks = 0;
    logic wrPulse;
    int nPulse = 0;
    // 250 MHz clock
    initial forever #2 clk = ~clk;
    prs_core #(.SIGNATURE(SIG), .PUW_COUNT(PUW), .RES1_COUNT(R1),
        .RES2_COUNT(R2)) i_prs_core (.clk(clk), .rst(rst), .link(link),
        .cycleBusy(cycleBusy), .qOut(qOut), .deepSleep(deepSleep),
        .standby(standby), .writeEnableLatch(write_enable_latch), .writeLock(writeLock),
        .writeCmdPulse(wrPulse), .acceptedOpcode(accOpc),
        .cycleBusyFlag(busyFlag));
    prs_host_model host (.clk(clk), .qOut(qOut), .link(link));
    // count accepted write commands, sampled mid-cycle
    always @(negedge clk)
        if (wrPulse === 1'b1)
            nPulse++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // write lock holds early write-enable off
    task automatic t_powerup;
        chk({deepSleep, standby, write_enable_latch, writeLock}, 4'h5);
        host.xfer(OPC_WRITE_ENABLE_CMD, 8, 0, rd);
        gap(8);
        chk(write_enable_latch, 1'h0);
        chk(16'(nPulse), 16'h0000);
        for (int i = 0; i < 2 * PUW && writeLock; i++) gap(1);
        host.xfer(OPC_WRITE_ENABLE_CMD, 8, 0, rd);
        gap(8);
        chk(write_enable_latch, 1'h1);
        chk(16'(nPulse), 16'h0001);
    endtask
    // two signature bytes; host then waits out the long release
    task automatic t_sig(input logic deep);
        host.xfer(OPC_RES_DEFAULT, 32, 16, rd);
        chk(rd, {SIG, SIG});
        gap(12);
        chk({deepSleep, standby}, {deep, ~deep});
        gap(R2 + 8);
        chk({deepSleep, standby}, 2'h1);
    endtask
    // nine bits is no entry; then writes are ignored in deep sleep
    task automatic t_deep;
        host.xfer(OPC_DEEP_SLEEP, 9, 0, rd);
        gap(8);
        chk(deepSleep, 1'h0);
        host.xfer(OPC_DEEP_SLEEP, 8, 0, rd);
        gap(8);
        chk(deepSleep, 1'h1);
        host.xfer(OPC_FULL_CLR, 8, 0, rd);
        gap(8);
        chk(accOpc, OPC_WRITE_ENABLE_CMD);
        chk(16'(nPulse), 16'h0001);
    endtask
    // select rises right after the opcode
    task automatic t_early;
        host.xfer(OPC_RES_DEFAULT, 8, 0, rd);
        gap(R1 + 8);
        chk({deepSleep, standby}, 2'h1);
    endtask
    // release is not decoded and deep sleep refused while busy
    task automatic t_busy;
        cycleBusy = 1'h1;
        gap(4);
        chk({busyFlag, standby}, 2'h2);
        host.xfer(OPC_RES_DEFAULT, 32, 8, rd);
        chk(host.enSeen, 1'h0);
        gap(8);
        host.xfer(OPC_DEEP_SLEEP, 8, 0, rd);
        gap(8);
        chk(deepSleep, 1'h0);
        cycleBusy = 1'h0;
        gap(4);
        chk(busyFlag, 1'h0);
    endtask
    // mid-run power-on reset out of deep sleep; release opcode sent under the lock, signature read after the lock ends
    task automatic t_reset;
        rst = 1'h1;
        gap(12);
        chk({qOut, deepSleep, write_enable_latch, writeLock}, 5'h01);
        rst = 1'h0;
        gap(8);
        chk({deepSleep, standby, write_enable_latch, writeLock}, 4'h5);
        t_sig(1'h0);
    endtask
    // main sequence
    initial
    begin
        gap(6);
        chk({qOut, deepSleep, write_enable_latch, writeLock}, 5'h01);
        gap(6);
        rst = 1'h0;
        gap(8);
        t_powerup();
        t_sig(1'h0);
        t_deep();
        t_sig(1'h1);
        t_deep();
        t_early();
        t_sig(1'h0);
        t_busy();
        t_deep();
        t_reset();
        wrap_up();
    end
    // hang guard, far beyond the expected run
    initial
    begin
        #100us;
        mismatches++;
        wrap_up();
    end
endmodule
